// >>> design/wrg_pkg.sv
// Constants, register map and period decode for the watchdog and reset guard
// How it works
// - Watchdog counts slow oscillator ticks, about 32 kHz, timeout 2^8 to 2^18 ticks
// - Period select 000..111 gives 2^8,2^10,2^12,2^14,2^15,2^16,2^17,2^18 ticks
// - Watchdog runs while its enable field holds 10101 or 01010
// - Any other enable code resets the device after the soft reset delay
// - Power-on loads watchdog control with 01010 011, that is 0x53
// - Bit 0 of the cause flags marks an enable-code reset; only writing zero clears
// - Overflow while running gives a full device reset and sets the expiry flag
// - Overflow while asleep sets the expiry flag and resets only PC and SP
// - Count clears on a bad enable code, the clear instruction or halt
// - Guard codes 0x55 and 0xaa do nothing; others reset after the delay
// - Guard code returns to 0x55 on every reset except a watchdog timeout
// - Bit 3 of the cause flags marks a guard-code reset; only writing zero clears
// - Upper four bits of the cause flag register read as zero
// - Power-on starts at address zero and presets all port registers high
// - Halt into sleep or idle clears the count and counting resumes
package wrg_pkg;
  // Register byte addresses
  localparam logic [7:0] WRG_ADDR_WDT_CTRL = 8'h00;
  localparam logic [7:0] WRG_ADDR_FLAGS = 8'h04;
  localparam logic [7:0] WRG_ADDR_GUARD = 8'h08;
  localparam logic [7:0] WRG_ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] WRG_ADDR_IRQ_MASK = 8'h10;
  // Field layout
  localparam int WRG_EN_LSB = 3;
  localparam int WRG_FLAG_WDT = 0;
  localparam int WRG_FLAG_GUARD = 3;
  localparam int WRG_EV_EXPIRY = 0;
  localparam int WRG_EV_CODE = 1;
  // Legal codes and reset values
  localparam logic [4:0] WRG_EN_CODE_A = 5'h15;
  localparam logic [4:0] WRG_EN_CODE_B = 5'h0a;
  localparam logic [7:0] WRG_GUARD_CODE_A = 8'h55;
  localparam logic [7:0] WRG_GUARD_CODE_B = 8'haa;
  localparam logic [7:0] WRG_WDT_CTRL_RST = 8'h53;
  localparam logic [7:0] WRG_GUARD_RST = 8'h55;
  localparam logic [3:0] WRG_FLAGS_RST = 4'h0;
  localparam logic [1:0] WRG_IRQ_RST = 2'h0;
  // Timing: system clock and slow oscillator
  localparam int WRG_CLK_HZ = 10_000_000;
  localparam int WRG_OSC_HZ = 32_000;
  localparam int WRG_OSC_DIV = WRG_CLK_HZ / WRG_OSC_HZ;
  localparam int WRG_SOFT_RESET_CYC = 16;
  localparam int WRG_CNT_W = 18;

  // Last count value before overflow for each period select
  function automatic logic [17:0] wrg_period_last(input logic [2:0] sel);
    logic [17:0] last;
    last = 18'h000ff;
    unique case (sel)
      3'h0: last = 18'h000ff;
      3'h1: last = 18'h003ff;
      3'h2: last = 18'h00fff;
      3'h3: last = 18'h03fff;
      3'h4: last = 18'h07fff;
      3'h5: last = 18'h0ffff;
      3'h6: last = 18'h1ffff;
      3'h7: last = 18'h3ffff;
    endcase
    return last;
  endfunction
endpackage

// >>> design/wrg_delay_if.sv
// Start and completion signals of the soft reset delay
`timescale 1ns/1ps
`default_nettype none
interface wrg_delay_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

// >>> design/wrg_divider.sv
// Divider giving a one-cycle tick at the slow oscillator rate
`timescale 1ns/1ps
`default_nettype none
module wrg_divider
  import wrg_pkg::*;
#(
  parameter int DIV = WRG_OSC_DIV
)
(
  input wire logic ref_clk,
  input wire logic reset,
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;

  // Free-running count; tick stands one cycle at each wrap
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> design/wrg_delay.sv
// Soft reset delay counter
`timescale 1ns/1ps
`default_nettype none
module wrg_delay
  import wrg_pkg::*;
#(
  parameter int CYC = WRG_SOFT_RESET_CYC
)
(
  input wire logic ref_clk,
  input wire logic reset,
  wrg_delay_if.timer dly
);
  localparam int W = $clog2(CYC + 1);
  logic [W-1:0] cnt;

  // Once started the delay cannot be cancelled; a fixed code must not mask noise
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt <= '0;
      dly.busy <= 1'b0;
      dly.done <= 1'b0;
    end
    else
    begin
      dly.done <= 1'b0;
      if (dly.busy)
      begin
        if (cnt == W'(CYC - 1))
        begin
          dly.busy <= 1'b0;
          dly.done <= 1'b1;
        end
        cnt <= cnt + 1'b1;
      end
      else if (dly.start)
      begin
        dly.busy <= 1'b1;
        cnt <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/wrg_top.sv
// Watchdog timer and reset guard with APB register access
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wrg_top
  import wrg_pkg::*;
#(
  parameter int OSC_DIV = WRG_OSC_DIV,
  parameter int SOFT_RESET_CYC = WRG_SOFT_RESET_CYC
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_watchdog_instruction,
  input wire logic halt_instr,
  input wire logic sleep_state,
  output logic device_reset,
  output logic warm_reset,
  output logic port_preset,
  output logic expiry_flag,
  output logic powerdown_flag,
  output logic irq
);
  localparam int DLY_MAX = SOFT_RESET_CYC + 3;

  logic [7:0] watchdog_control;
  logic [7:0] reset_guard_code;
  logic [3:0] reset_cause_flags;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [WRG_CNT_W-1:0] count;
  logic osc_tick;
  logic rst_by_wdt;
  logic pend_wdt;
  logic pend_guard;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic en_ok;
  logic guard_ok;
  logic full_rst;
  logic guard_rst;
  logic cnt_clear;
  logic timeout;
  logic [31:0] rdata;
  logic [1:0] events;
  wrg_delay_if dly ();

  wrg_divider #(.DIV(OSC_DIV)) u_div (
    .ref_clk(ref_clk),
    .reset(reset),
    .tick(osc_tick)
  );

  wrg_delay #(.CYC(SOFT_RESET_CYC)) u_dly (
    .ref_clk(ref_clk),
    .reset(reset),
    .dly(dly)
  );

  // Bus decode; a write or read-clear acts only at the edge that completes the transfer
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign mapped = (paddr == WRG_ADDR_WDT_CTRL) || (paddr == WRG_ADDR_FLAGS) ||
                  (paddr == WRG_ADDR_GUARD) || (paddr == WRG_ADDR_IRQ_STAT) ||
                  (paddr == WRG_ADDR_IRQ_MASK);

  // Code checks
  assign en_ok = (watchdog_control[7:WRG_EN_LSB] == WRG_EN_CODE_A) ||
                 (watchdog_control[7:WRG_EN_LSB] == WRG_EN_CODE_B);
  assign guard_ok = (reset_guard_code == WRG_GUARD_CODE_A) ||
                    (reset_guard_code == WRG_GUARD_CODE_B);

  // Our own full reset re-inits registers; a watchdog one spares the guard code
  assign full_rst = reset | device_reset;
  assign guard_rst = reset | (device_reset & ~rst_by_wdt);

  // Count clear sources and overflow detection
  assign cnt_clear = ~en_ok | clear_watchdog_instruction | halt_instr;
  // Compare with >= so that a shorter period chosen mid-count still expires
  assign timeout = osc_tick & ~cnt_clear & (count >= wrg_period_last(watchdog_control[2:0]));
  // Not in the completion cycle: the codes are only reloaded by the reset that follows
  assign dly.start = ~(en_ok & guard_ok) & ~dly.busy & ~dly.done & ~device_reset;
  assign events = {dly.start, timeout};

  // Watchdog counter on the slow tick
  always_ff @(posedge ref_clk)
  begin
    if (full_rst | warm_reset | cnt_clear)
      count <= '0;
    else if (timeout)
      count <= '0;
    else if (osc_tick)
      count <= count + 1'b1;
  end

  // Watchdog control register
  always_ff @(posedge ref_clk)
  begin
    if (full_rst)
      watchdog_control <= WRG_WDT_CTRL_RST;
    else if (wr && paddr == WRG_ADDR_WDT_CTRL)
      watchdog_control <= pwdata[7:0];
  end

  // Guard code register
  always_ff @(posedge ref_clk)
  begin
    if (guard_rst)
      reset_guard_code <= WRG_GUARD_RST;
    else if (wr && paddr == WRG_ADDR_GUARD)
      reset_guard_code <= pwdata[7:0];
  end

  // Pending causes are gathered while the delay runs so none is lost
  always_ff @(posedge ref_clk)
  begin
    if (full_rst)
    begin
      pend_wdt <= 1'b0;
      pend_guard <= 1'b0;
    end
    else
    begin
      pend_wdt <= pend_wdt | ~en_ok;
      pend_guard <= pend_guard | ~guard_ok;
    end
  end

  // Reset outputs; sleep decides between full and warm reset
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      device_reset <= 1'b0;
      warm_reset <= 1'b0;
      rst_by_wdt <= 1'b0;
      port_preset <= 1'b1;
    end
    else
    begin
      port_preset <= 1'b0;
      device_reset <= dly.done | (timeout & ~sleep_state);
      warm_reset <= timeout & sleep_state;
      rst_by_wdt <= timeout & ~sleep_state;
    end
  end

  // Cause flags: hardware sets, only a written zero clears, and set wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reset_cause_flags <= WRG_FLAGS_RST;
    else
    begin
      if (wr && paddr == WRG_ADDR_FLAGS)
        reset_cause_flags <= reset_cause_flags & pwdata[3:0] |
          {dly.done & pend_guard, 2'b00, dly.done & pend_wdt};
      else
      begin
        if (dly.done & pend_wdt)
          reset_cause_flags[WRG_FLAG_WDT] <= 1'b1;
        if (dly.done & pend_guard)
          reset_cause_flags[WRG_FLAG_GUARD] <= 1'b1;
      end
    end
  end

  // Expiry and power-down flags; a clear or halt in the overflow cycle blocks the timeout, so the clear wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      expiry_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end
    else
    begin
      if (timeout)
        expiry_flag <= 1'b1;
      else if (halt_instr | clear_watchdog_instruction)
        expiry_flag <= 1'b0;
      if (halt_instr)
        powerdown_flag <= 1'b1;
      else if (clear_watchdog_instruction)
        powerdown_flag <= 1'b0;
    end
  end

  // Interrupt status clears on read, new events win; mask is plain storage
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      irq_status <= WRG_IRQ_RST;
      irq_mask <= WRG_IRQ_RST;
      irq <= 1'b0;
    end
    else
    begin
      // Clear only what the read reported, so an event caught after capture stays
      if (rd && paddr == WRG_ADDR_IRQ_STAT)
        irq_status <= (irq_status & ~prdata[1:0]) | events;
      else
        irq_status <= irq_status | events;
      if (wr && paddr == WRG_ADDR_IRQ_MASK)
        irq_mask <= pwdata[1:0];
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read mux; unused upper bits read zero
  always_comb
  begin
    rdata = 32'h0;
    unique case (paddr)
      WRG_ADDR_WDT_CTRL: rdata = {24'h0, watchdog_control};
      WRG_ADDR_FLAGS: rdata = {28'h0, reset_cause_flags};
      WRG_ADDR_GUARD: rdata = {24'h0, reset_guard_code};
      WRG_ADDR_IRQ_STAT: rdata = {30'h0, irq_status};
      WRG_ADDR_IRQ_MASK: rdata = {30'h0, irq_mask};
      default: rdata = 32'h0;
    endcase
  end

  // One wait state: data is registered so every output is a flop
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready)
      begin
        prdata <= pwrite ? 32'h0 : rdata;
        pslverr <= ~mapped;
      end
      else
        pslverr <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Timeout outcomes: awake gives a full reset, asleep only a warm one
  a_timeout_full: assert property (timeout && !sleep_state |=> device_reset && expiry_flag)
    else $error("Timeout while running gave no full reset");
  a_timeout_warm: assert property (timeout && sleep_state |=> warm_reset && !device_reset)
    else $error("Timeout while asleep gave wrong reset");

  // Bad codes start the delay at once and end in exactly one full reset
  a_bad_en_start: assert property ($fell(en_ok) && !dly.busy && !dly.done &&
      !device_reset |=> dly.busy)
    else $error("Bad enable code did not start the delay");
  a_bad_guard_start: assert property ($fell(guard_ok) && !dly.busy && !dly.done &&
      !device_reset |=> dly.busy)
    else $error("Bad guard code did not start the delay");
  a_bad_code_rst: assert property ($rose(dly.busy) |-> ##[1:DLY_MAX] device_reset)
    else $error("Bad code did not reset after the delay");
  a_done_pulse: assert property (dly.done |=> !dly.done)
    else $error("Delay completion held too long");
  a_no_restart: assert property (dly.done |=> !dly.busy ##1 !dly.busy)
    else $error("Delay restarted on its own completion");
  a_ctrl_reload: assert property (device_reset |=> watchdog_control == WRG_WDT_CTRL_RST)
    else $error("Watchdog control not reloaded by device reset");

  // Counter clears, steps once per slow tick and holds between ticks
  a_count_clear: assert property (halt_instr || clear_watchdog_instruction |=> count == 0)
    else $error("Count not cleared");
  a_count_bad_en: assert property (!en_ok |=> count == 0)
    else $error("Count not held clear under a bad enable code");
  a_count_step: assert property (osc_tick && !cnt_clear && !timeout && !full_rst &&
      !warm_reset |=> count == $past(count) + 1)
    else $error("Count did not step on a slow tick");
  a_count_hold: assert property (!osc_tick && !cnt_clear && !full_rst && !warm_reset |=>
      $stable(count))
    else $error("Count moved between slow ticks");
  a_halt_pd: assert property (halt_instr |=> powerdown_flag && !expiry_flag)
    else $error("Halt did not set power-down and clear expiry");
  a_preset_release: assert property ($fell(reset) |-> port_preset ##1 !port_preset)
    else $error("Port preset not released after reset");

  // Interrupt status is sticky and the line follows status and mask
  a_stat_expiry: assert property (timeout |=> irq_status[WRG_EV_EXPIRY])
    else $error("Timeout event not recorded");
  a_stat_code: assert property (dly.start |=> irq_status[WRG_EV_CODE])
    else $error("Bad code event not recorded");
  a_unread_kept: assert property (rd && paddr == WRG_ADDR_IRQ_STAT && irq_status[0] &&
      !prdata[0] |=> irq_status[0])
    else $error("Unreported timeout event lost by a read");
  a_irq_high: assert property ((|(irq_status & irq_mask)) |=> irq)
    else $error("Unmasked event did not raise the interrupt");
  a_irq_low: assert property (!(|(irq_status & irq_mask)) |=> !irq)
    else $error("Interrupt high with no unmasked event");

  // Bus answers after one wait state and flags unmapped addresses
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("Ready held for more than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("Slave error does not match the address map");
  a_upper_zero: assert property (pready && !pwrite && paddr == WRG_ADDR_FLAGS |->
      prdata[31:4] == 28'h0)
    else $error("Upper flag bits not zero");

  // Cause flags are set by the delayed reset and cleared only by a written zero
  a_wdt_flag_set: assert property (dly.done && pend_wdt |=>
      reset_cause_flags[WRG_FLAG_WDT])
    else $error("Enable-code flag not set");
  a_guard_flag_set: assert property (dly.done && pend_guard |=>
      reset_cause_flags[WRG_FLAG_GUARD])
    else $error("Guard-code flag not set");
  a_flag_sticky: assert property (reset_cause_flags[WRG_FLAG_WDT] &&
      !(wr && paddr == WRG_ADDR_FLAGS && !pwdata[WRG_FLAG_WDT]) |=>
      reset_cause_flags[WRG_FLAG_WDT])
    else $error("Enable-code flag cleared without a zero write");
  a_guard_sticky: assert property (reset_cause_flags[WRG_FLAG_GUARD] &&
      !(wr && paddr == WRG_ADDR_FLAGS && !pwdata[WRG_FLAG_GUARD]) |=>
      reset_cause_flags[WRG_FLAG_GUARD])
    else $error("Guard-code flag cleared without a zero write");

  // Guard code survives a watchdog reset and is restored by any other
  a_guard_kept: assert property (device_reset && rst_by_wdt &&
      !(wr && paddr == WRG_ADDR_GUARD) |=> $stable(reset_guard_code))
    else $error("Guard code changed on watchdog reset");
  a_guard_por: assert property (device_reset && !rst_by_wdt |=>
      reset_guard_code == WRG_GUARD_RST)
    else $error("Guard code not restored");
  a_por_value: assert property ($fell(reset) |-> watchdog_control == WRG_WDT_CTRL_RST)
    else $error("Watchdog control reset value wrong");
endmodule
`default_nettype wire

// >>> test/wrg_top_test.sv
// Self-checking testbench for the watchdog and reset guard block
`timescale 1ns/1ps
`default_nettype none
module wrg_top_test;
  import wrg_pkg::*;
  localparam int DIV = 2;
  localparam int SRC = 4;
  localparam logic [7:0] BAD_ADDR [2] = '{WRG_ADDR_GUARD, WRG_ADDR_WDT_CTRL};
  localparam logic [7:0] BAD_CODE [2] = '{8'h12, 8'h03};
  localparam int BAD_BIT [2] = '{WRG_FLAG_GUARD, WRG_FLAG_WDT};
  logic ref_clk, reset, psel, penable, pwrite;
  logic clear_watchdog_instruction, halt_instr, sleep_state;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, device_reset, warm_reset, port_preset;
  logic expiry_flag, powerdown_flag, irq, er, dev, warm;
  int error_cnt, checks_done, n;

  wrg_top #(.OSC_DIV(DIV), .SOFT_RESET_CYC(SRC)) wrg_top_i (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .clear_watchdog_instruction(clear_watchdog_instruction),
    .halt_instr(halt_instr), .sleep_state(sleep_state),
    .device_reset(device_reset), .warm_reset(warm_reset), .port_preset(port_preset),
    .expiry_flag(expiry_flag), .powerdown_flag(powerdown_flag), .irq(irq)
  );

  // 10 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      check(32'h0, 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Counts edges until a reset pulse is sampled or the limit runs out
  task automatic wait_rst(input int limit);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (device_reset !== 1'b1 && warm_reset !== 1'b1 && n < limit);
    dev = device_reset;
    warm = warm_reset;
  endtask

  task automatic pulse(input logic use_halt);
    @(posedge ref_clk);
    if (use_halt)
      halt_instr <= 1'b1;
    else
      clear_watchdog_instruction <= 1'b1;
    @(posedge ref_clk);
    halt_instr <= 1'b0;
    clear_watchdog_instruction <= 1'b0;
  endtask

  // Timeout length after a clear or halt; divider phase allows a few cycles of slack
  task automatic period(input logic [7:0] ctrl, input logic hs, input int exp);
    xfer(1'b1, WRG_ADDR_WDT_CTRL, {24'h0, ctrl});
    sleep_state <= hs;
    pulse(hs);
    wait_rst(exp + 50);
    check(32'(n >= exp - 4 && n <= exp + 4), 32'h1);
    check(dev, !hs);
    check(warm, hs);
    check(expiry_flag, 1'b1);
    check(powerdown_flag, hs);
    sleep_state <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {clear_watchdog_instruction, halt_instr, sleep_state} = 3'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk);
    check(port_preset, 1'b1);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(port_preset, 1'b0);
    rd_chk(WRG_ADDR_WDT_CTRL, 32'h53);
    rd_chk(WRG_ADDR_GUARD, 32'h55);
    rd_chk(WRG_ADDR_FLAGS, 32'h0);
    rd_chk(WRG_ADDR_IRQ_STAT, 32'h0);
    xfer(1'b1, 8'h14, 32'hff);
    check(er, 1'b1);
    rd_chk(8'h14, 32'h0);
    check(er, 1'b1);
    xfer(1'b1, WRG_ADDR_IRQ_MASK, 32'h3);
    rd_chk(WRG_ADDR_IRQ_MASK, 32'h3);
    xfer(1'b1, WRG_ADDR_GUARD, 32'haa);
    wait_rst(40);
    check(dev, 1'b0);
    rd_chk(WRG_ADDR_GUARD, 32'haa);
    // Illegal guard code, then illegal enable field
    for (int i = 0; i < 2; i++)
    begin
      xfer(1'b1, BAD_ADDR[i], {24'h0, BAD_CODE[i]});
      wait_rst(40);
      check(dev, 1'b1);
      check(32'(n >= SRC && n <= SRC + 4), 32'h1);
      check(irq, 1'b1);
      rd_chk(WRG_ADDR_FLAGS, 32'h1 << BAD_BIT[i]);
      rd_chk(WRG_ADDR_GUARD, 32'h55);
      rd_chk(WRG_ADDR_WDT_CTRL, 32'h53);
      rd_chk(WRG_ADDR_IRQ_STAT, 32'h2);
      rd_chk(WRG_ADDR_IRQ_STAT, 32'h0);
      check(irq, 1'b0);
      xfer(1'b1, WRG_ADDR_FLAGS, 32'hff);
      rd_chk(WRG_ADDR_FLAGS, 32'h1 << BAD_BIT[i]);
      xfer(1'b1, WRG_ADDR_FLAGS, 32'h0);
      rd_chk(WRG_ADDR_FLAGS, 32'h0);
    end
    // Timeouts: guard code must survive them; timeout interrupt masked
    xfer(1'b1, WRG_ADDR_GUARD, 32'haa);
    xfer(1'b1, WRG_ADDR_IRQ_MASK, 32'h2);
    period(8'h50, 1'b0, 256 * DIV);
    period(8'ha9, 1'b0, 1024 * DIV);
    period(8'h53, 1'b0, 16384 * DIV);
    period(8'h52, 1'b1, 4096 * DIV);
    check(irq, 1'b0);
    rd_chk(WRG_ADDR_IRQ_STAT, 32'h1);
    rd_chk(WRG_ADDR_GUARD, 32'haa);
    pulse(1'b0);
    @(posedge ref_clk);
    check({expiry_flag, powerdown_flag}, 2'b00);
    // Regular clearing keeps the shortest period from expiring
    xfer(1'b1, WRG_ADDR_WDT_CTRL, 32'h50);
    repeat (6)
    begin
      pulse(1'b0);
      wait_rst(400);
      check(dev | warm, 1'b0);
    end
    final_report();
  end

  // Hang guard, well beyond the expected run length
  initial
  begin
    #(60000 * 100);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
